// ===== rtl/pet_params.svh
// constants for the preloadable event timer
`ifndef PET_PARAMS_SVH
`define PET_PARAMS_SVH

// register port widths
`define PET_ADDR_W 2
`define PET_DATA_W 8

// register indices on the register port
`define PET_IDX_CTRL 2'h0
`define PET_IDX_CNT_LO 2'h1
`define PET_IDX_CNT_HI 2'h2

// control register field positions
`define PET_MODE_HI 7
`define PET_MODE_LO 6
`define PET_RUN_BIT 4
`define PET_EDGE_BIT 3
`define PET_RATIO_HI 2
`define PET_RATIO_LO 0
`define PET_RATIO_W 3

// mode field encodings
`define PET_MODE_OFF 2'h0
`define PET_MODE_EVENT 2'h1
`define PET_MODE_TIMER 2'h2
`define PET_MODE_PULSE 2'h3

// reset values
`define PET_CTRL_RST 8'h00
`define PET_BYTE_RST 8'h00

// prescaler counter width, largest divide is 2 to the 7th
`define PET_DIV_W 7

`endif

// ===== rtl/pet_pkg.sv
// types shared by the preloadable event timer files
`default_nettype none
`include "pet_params.svh"

package pet_pkg;

    // one register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [`PET_ADDR_W-1:0] addr;
        logic [`PET_DATA_W-1:0] wdata;
    } pet_req_t;

    // pulse-width measurement phases
    typedef enum logic [0:0] {
        PET_PW_WAIT,
        PET_PW_MEAS
    } pet_pw_state_t;

endpackage
`default_nettype wire

// ===== rtl/pet_tick_gen.sv
// prescaler and event pin synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none
`include "pet_params.svh"

module pet_tick_gen (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // prescaler control
    input wire logic div_run,
    input wire logic [`PET_RATIO_W-1:0] ratio,
    output logic div_tick,
    // event pin
    input wire logic event_input_pin,
    output logic pin_rise,
    output logic pin_fall
);

    logic [`PET_DIV_W-1:0] div_r;
    logic [`PET_DIV_W-1:0] div_nxt;
    logic [`PET_DIV_W-1:0] mask;
    logic sync1_r;
    logic sync2_r;
    logic prev_r;

    // divide by two to the ratio
    always_comb begin
        mask = `PET_DIV_W'(({{(`PET_DIV_W){1'b0}}, 1'b1} << ratio) - 1'b1);
        div_tick = div_run && ((div_r & mask) == mask);
        if (!div_run || div_tick) begin
            div_nxt = '0;
        end else begin
            div_nxt = div_r + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_r <= '0;
        end else begin
            div_r <= div_nxt;
        end
    end

    // two-stage synchroniser plus history
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            sync1_r <= event_input_pin;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    assign pin_rise = sync2_r && !prev_r;
    assign pin_fall = !sync2_r && prev_r;

endmodule
`default_nettype wire

// ===== rtl/pet_timer.sv
// preloadable event timer with control and count registers
`timescale 1ns/1ps
`default_nettype none
`include "pet_params.svh"

// Functional notes
// - up counter, 8 or 16 bits, three modes
// - read gives count, write preloads
// - timer and pulse modes use prescaled clock
// - event mode counts selected pin edges
// - overflow past all ones raises request
// - overflow reloads preload and keeps counting
// - preload register has no reset value
// - stopped counter takes preload writes directly
// - running counter takes preload at overflow
// - 16-bit low byte write only fills buffer
// - high byte write commits buffer too
// - high byte read latches low count
// - 16-bit low byte read returns latched buffer
// - mode field bits 7:6 select mode
// - control bit 4 is run bit
// - control bit 3 selects edge polarity
// - pulse end clears run, edges ignored
module pet_timer
    import pet_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire pet_req_t reg_req,
    output logic [`PET_DATA_W-1:0] rd_data,
    // external event pin
    input wire logic event_input_pin,
    // status
    output logic overflow_req,
    output logic run_bit,
    output logic [WIDTH-1:0] count_value
);

    // only 8 and 16 bit widths
    if (WIDTH != 8 && WIDTH != 16) begin : g_bad_width
        $error("pet_timer: WIDTH must be 8 or 16");
    end

    localparam bit IS16 = (WIDTH == 16);
    localparam logic [7:0] CTRL_RST = `PET_CTRL_RST;

    // control register fields
    logic [1:0] operating_mode_pair_r;
    logic [1:0] operating_mode_pair_nxt;
    logic run_bit_r;
    logic run_bit_nxt;
    logic edge_polarity_sel_r;
    logic edge_polarity_sel_nxt;
    logic [`PET_RATIO_W-1:0] divide_ratio_field_r;
    logic [`PET_RATIO_W-1:0] divide_ratio_field_nxt;

    // counting state
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;
    logic [WIDTH-1:0] pre_r;
    logic [WIDTH-1:0] pre_nxt;
    logic [7:0] lo_buf_r;
    logic [7:0] lo_buf_nxt;
    logic ovf_r;
    logic ovf_nxt;
    pet_pw_state_t pw_r;
    pet_pw_state_t pw_nxt;

    // register read path
    logic [7:0] rd_data_r;
    logic [7:0] rd_data_nxt;

    // decode and event terms
    logic wr_ctrl;
    logic wr_lo;
    logic wr_hi;
    logic rd_ctrl;
    logic rd_lo;
    logic rd_hi;
    logic pre_wr;
    logic [15:0] pre_wide;
    logic [WIDTH-1:0] pre_val;
    logic counting;
    logic internal_src;
    logic div_tick;
    logic pin_rise;
    logic pin_fall;
    logic sel_edge;
    logic start_edge;
    logic end_edge;
    logic inc;
    logic hw_stop;
    logic [7:0] ctrl_view;
    logic [7:0] hi_byte;

    // internal clock source only in timer and pulse modes
    assign internal_src = (operating_mode_pair_r == `PET_MODE_TIMER)
                       || (operating_mode_pair_r == `PET_MODE_PULSE);

    pet_tick_gen u_tick (
        .clk(clk),
        .rst(rst),
        .div_run(internal_src && run_bit_r),
        .ratio(divide_ratio_field_r),
        .div_tick(div_tick),
        .event_input_pin(event_input_pin),
        .pin_rise(pin_rise),
        .pin_fall(pin_fall)
    );

    // address decode
    always_comb begin
        wr_ctrl = reg_req.wr && (reg_req.addr == `PET_IDX_CTRL);
        wr_lo = reg_req.wr && (reg_req.addr == `PET_IDX_CNT_LO);
        wr_hi = reg_req.wr && (reg_req.addr == `PET_IDX_CNT_HI) && IS16;
        rd_ctrl = reg_req.rd && (reg_req.addr == `PET_IDX_CTRL);
        rd_lo = reg_req.rd && (reg_req.addr == `PET_IDX_CNT_LO);
        rd_hi = reg_req.rd && (reg_req.addr == `PET_IDX_CNT_HI) && IS16;
    end

    always_comb begin
        pre_wr = IS16 ? wr_hi : wr_lo;
        pre_wide = IS16 ? {reg_req.wdata, lo_buf_r} : {8'h00, reg_req.wdata};
        pre_val = pre_wide[WIDTH-1:0];
    end

    assign counting = run_bit_r && (operating_mode_pair_r != `PET_MODE_OFF);

    // edge choice for event and pulse modes
    always_comb begin
        sel_edge = edge_polarity_sel_r ? pin_fall : pin_rise;
        start_edge = edge_polarity_sel_r ? pin_rise : pin_fall;
        end_edge = edge_polarity_sel_r ? pin_fall : pin_rise;
    end

    // pulse-width measurement sequence
    always_comb begin
        pw_nxt = pw_r;
        hw_stop = 1'b0;
        if (operating_mode_pair_r != `PET_MODE_PULSE || !run_bit_r) begin
            pw_nxt = PET_PW_WAIT;
        end else begin
            case (pw_r)
                PET_PW_WAIT: begin
                    if (start_edge) begin
                        pw_nxt = PET_PW_MEAS;
                    end
                end
                PET_PW_MEAS: begin
                    // pin back to idle level stops
                    if (end_edge) begin
                        pw_nxt = PET_PW_WAIT;
                        hw_stop = 1'b1;
                    end
                end
                default: begin
                    pw_nxt = PET_PW_WAIT;
                end
            endcase
        end
    end

    // increment source per mode
    always_comb begin
        case (operating_mode_pair_r)
            `PET_MODE_TIMER: inc = run_bit_r && div_tick;
            `PET_MODE_EVENT: inc = run_bit_r && sel_edge;
            `PET_MODE_PULSE: inc = run_bit_r && (pw_r == PET_PW_MEAS) && div_tick && !end_edge;
            default: inc = 1'b0;
        endcase
    end

    // control register next values
    always_comb begin
        operating_mode_pair_nxt = operating_mode_pair_r;
        run_bit_nxt = run_bit_r;
        edge_polarity_sel_nxt = edge_polarity_sel_r;
        divide_ratio_field_nxt = divide_ratio_field_r;
        if (hw_stop) begin
            run_bit_nxt = 1'b0;
        end
        if (wr_ctrl) begin
            operating_mode_pair_nxt = reg_req.wdata[`PET_MODE_HI:`PET_MODE_LO];
            run_bit_nxt = reg_req.wdata[`PET_RUN_BIT];
            edge_polarity_sel_nxt = reg_req.wdata[`PET_EDGE_BIT];
            divide_ratio_field_nxt = reg_req.wdata[`PET_RATIO_HI:`PET_RATIO_LO];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            operating_mode_pair_r <= CTRL_RST[`PET_MODE_HI:`PET_MODE_LO];
            run_bit_r <= CTRL_RST[`PET_RUN_BIT];
            edge_polarity_sel_r <= CTRL_RST[`PET_EDGE_BIT];
            divide_ratio_field_r <= CTRL_RST[`PET_RATIO_HI:`PET_RATIO_LO];
            pw_r <= PET_PW_WAIT;
        end else begin
            operating_mode_pair_r <= operating_mode_pair_nxt;
            run_bit_r <= run_bit_nxt;
            edge_polarity_sel_r <= edge_polarity_sel_nxt;
            divide_ratio_field_r <= divide_ratio_field_nxt;
            pw_r <= pw_nxt;
        end
    end

    // counter, preload and overflow next values
    always_comb begin
        pre_nxt = pre_r;
        cnt_nxt = cnt_r;
        ovf_nxt = 1'b0;
        // running counter sees only preload change
        if (pre_wr) begin
            pre_nxt = pre_val;
        end
        if (pre_wr && !counting) begin
            cnt_nxt = pre_val;
        end else if (inc) begin
            if (&cnt_r) begin
                cnt_nxt = pre_nxt;
                ovf_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    // preload keeps whatever it held, no reset
    always_ff @(posedge clk) begin
        pre_r <= pre_nxt;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            ovf_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            ovf_r <= ovf_nxt;
        end
    end

    // low byte buffer and read data next values
    always_comb begin
        lo_buf_nxt = lo_buf_r;
        rd_data_nxt = rd_data_r;
        ctrl_view = {operating_mode_pair_r, 1'b0, run_bit_r, edge_polarity_sel_r, divide_ratio_field_r};
        hi_byte = 8'(cnt_r >> 8);
        if (rd_hi) begin
            lo_buf_nxt = cnt_r[7:0];
        end
        if (wr_lo && IS16) begin
            lo_buf_nxt = reg_req.wdata;
        end
        if (reg_req.rd) begin
            rd_data_nxt = 8'h00;
            if (rd_ctrl) begin
                rd_data_nxt = ctrl_view;
            end
            if (rd_lo) begin
                rd_data_nxt = IS16 ? lo_buf_r : cnt_r[7:0];
            end
            if (rd_hi) begin
                rd_data_nxt = hi_byte;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lo_buf_r <= `PET_BYTE_RST;
            rd_data_r <= `PET_BYTE_RST;
        end else begin
            lo_buf_r <= lo_buf_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end

    // outputs
    assign rd_data = rd_data_r;
    assign overflow_req = ovf_r;
    assign run_bit = run_bit_r;
    assign count_value = cnt_r;

endmodule
`default_nettype wire

// ===== tb/pet_timer_properties.sv
// port assertions for the event timer
`timescale 1ns/1ps
`default_nettype none
`include "pet_params.svh"
module pet_timer_properties
    import pet_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // watched ports
    input wire logic clk,
    input wire logic rst,
    input wire pet_req_t reg_req,
    input wire logic [`PET_DATA_W-1:0] rd_data,
    input wire logic overflow_req,
    input wire logic run_bit,
    input wire logic [WIDTH-1:0] count_value
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire ctl_wr = reg_req.wr && reg_req.addr == `PET_IDX_CTRL;
    wire hi_wr = reg_req.wr && reg_req.addr == `PET_IDX_CNT_HI;
    sequence s_hi_rd;
        reg_req.rd && !reg_req.wr && reg_req.addr == `PET_IDX_CNT_HI;
    endsequence
    sequence s_lo_rd;
        reg_req.rd && !reg_req.wr && reg_req.addr == `PET_IDX_CNT_LO;
    endsequence
    property p_rd_pair;
        s_hi_rd ##1 !reg_req.wr && !reg_req.rd ##1 s_lo_rd |=> rd_data == $past(count_value[7:0], 3);
    endproperty
    property p_rd_hi;
        s_hi_rd |=> rd_data == $past(count_value[WIDTH-1:8]);
    endproperty
    property p_rd_hold;
        !reg_req.rd |=> $stable(rd_data);
    endproperty
    property p_ovf;
        overflow_req |-> $past(&count_value);
    endproperty
    property p_run_wr;
        ctl_wr |=> run_bit == $past(reg_req.wdata[`PET_RUN_BIT]);
    endproperty
    property p_hold;
        !run_bit && !ctl_wr && !hi_wr |=> $stable(count_value);
    endproperty
    property p_hi_load;
        hi_wr && !run_bit |=> count_value[WIDTH-1:8] == $past(reg_req.wdata);
    endproperty
    property p_pw_end;
        $fell(run_bit) && !$past(ctl_wr) |=> $stable(count_value) [*3];
    endproperty
    a_rd_pair: assert property (p_rd_pair) else $error("low read not latched");
    a_rd_hi: assert property (p_rd_hi) else $error("high read wrong");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    a_ovf: assert property (p_ovf) else $error("overflow not from all ones");
    a_run_wr: assert property (p_run_wr) else $error("run bit not written");
    a_hold: assert property (p_hold) else $error("stopped count moved");
    a_hi_load: assert property (p_hi_load) else $error("stopped load missed");
    a_pw_end: assert property (p_pw_end) else $error("count moved after pulse");
endmodule
bind pet_timer pet_timer_properties #(.WIDTH(WIDTH)) i_props (.clk(clk), .rst(rst),
    .reg_req(reg_req), .rd_data(rd_data), .overflow_req(overflow_req),
    .run_bit(run_bit), .count_value(count_value));
`default_nettype wire

// ===== tb/pet_pin_model.sv
// pulse source on the timer event pin
`timescale 1ns/1ps
`default_nettype none
module pet_pin_model (
    // clock and pin
    input wire logic clk,
    output logic pin
);
    initial pin = 1'b0;
    task automatic idle(input logic lvl);
        @(posedge clk);
        pin <= lvl;
    endtask
    // active then idle, each n cycles
    task automatic pulse(input logic act, input int n);
        @(posedge clk);
        pin <= act;
        repeat (n) @(posedge clk);
        pin <= ~act;
        repeat (n - 1) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ===== tb/preloadable_event_timer_tb.sv
// self-checking bench for the event timer
`timescale 1ns/1ps
`default_nettype none
`include "pet_params.svh"
module preloadable_event_timer_tb import pet_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    pet_req_t req = '0;
    logic [7:0] rd_data, rdv;
    logic pin, ovf, run;
    logic [15:0] cnt;
    int failures = 0;
    int total_checks = 0;
    int cyc = 0;
    int seed = 32'hf0a0;
    always #2 clk = ~clk;
    pet_timer #(.WIDTH(16)) i_dut (.clk(clk), .rst(rst), .reg_req(req), .rd_data(rd_data),
        .event_input_pin(pin), .overflow_req(ovf), .run_bit(run), .count_value(cnt));
    pet_pin_model i_pin (.clk(clk), .pin(pin));
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    // cycles between overflows for n increments at ratio r
    function automatic int ovf_cycles(input int n, input int r);
        return n << r;
    endfunction
    // ticks counted over a k-cycle pulse, end cycle excluded
    function automatic int pw_ticks(input int k);
        return k - 1;
    endfunction
    task automatic conclude;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: w, rd: ~w, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
        #1 rdv = rd_data;
    endtask
    task automatic ld16(input logic [15:0] v);
        acc(1, 1, v[7:0]);
        acc(1, 2, v[15:8]);
    endtask
    task automatic wait_ovf(output int c);
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while (ovf !== 1'b1 && c < 5000);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        int c, k;
        logic [15:0] v;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (4) begin
            v = $random(seed);
            ld16(v);
            chk("count", cnt, v);
            acc(0, 2, 0);
            chk("read high", rdv, v[15:8]);
            acc(0, 1, 0);
            chk("read low", rdv, v[7:0]);
            acc(1, 1, ~v[7:0]);
            chk("low write", cnt, v);
        end
        v = $random(seed);
        acc(1, 0, v[7:0]);
        acc(0, 0, 0);
        chk("control", rdv, {v[7:6], 1'b0, v[4:0]});
        chk("run", run, v[4]);
        acc(1, 3, 8'hff);
        acc(0, 3, 0);
        chk("unmapped", rdv, 0);
        for (int r = 0; r < 3; r++) begin
            acc(1, 0, 0);
            ld16(16'hfffe);
            acc(1, 0, {`PET_MODE_TIMER, 3'b010, r[2:0]});
            wait_ovf(c);
            wait_ovf(c);
            chk("period", c, ovf_cycles(2, r));
            chk("reload", cnt, 16'hfffe);
        end
        ld16(16'hfffd);
        chk("early load", cnt == 16'hfffd, 0);
        wait_ovf(c);
        chk("new reload", cnt, 16'hfffd);
        wait_ovf(c);
        chk("period", c, ovf_cycles(3, 2));
        for (int e = 0; e < 2; e++) begin
            acc(1, 0, 0);
            i_pin.idle(e[0]);
            v = {1'b0, 15'($random(seed))};
            ld16(v);
            k = 1 + $unsigned($random(seed)) % 4;
            acc(1, 0, {`PET_MODE_EVENT, 2'b01, e[0], 3'b111});
            repeat (k) i_pin.pulse(~e[0], 3);
            repeat (6) @(posedge clk);
            chk("events", cnt, 16'(v + k));
            acc(1, 0, {2'b00, 2'b01, e[0], 3'b000});
            i_pin.pulse(~e[0], 3);
            repeat (6) @(posedge clk);
            chk("off mode", cnt, 16'(v + k));
        end
        for (int e = 0; e < 2; e++) begin
            acc(1, 0, 0);
            i_pin.idle(~e[0]);
            ld16(16'h0000);
            k = 4 + $unsigned($random(seed)) % 8;
            acc(1, 0, {`PET_MODE_PULSE, 2'b01, e[0], 3'b000});
            i_pin.pulse(e[0], k);
            repeat (4) @(posedge clk);
            chk("run clear", run, 0);
            v = cnt;
            chk("width", v, pw_ticks(k));
            i_pin.pulse(e[0], k);
            repeat (4) @(posedge clk);
            chk("ignored", cnt, v);
        end
        conclude();
    end
endmodule
`default_nettype wire
